// File: core/ppmsi_regs.sv
// Port power-management and MSI configuration registers.
`timescale 1ns/1ps
`include "ppmsi_defines.svh"

// Operation
// - Power state field reads current state; writes of 0 or 3 accepted.
// - No-soft-reset bit resets to one, writable only with lock open.
// - Enable bit lets the port send PME messages; resets zero, sticky.
// - Hot reset leaves the PME enable bit untouched.
// - Own PME sets sticky status even when disabled; write one clears.
// - Forwarded PME messages leave the status bit alone.
// - Upstream port never sets its PME status.
// - Data select, scale and data byte read zero.
// - MSI header reads capability identifier five in bits 7:0.
// - Next pointer defaults zero, writable only with lock open.
// - Bit 16 enables MSI; resets disabled.
// - One vector only: multi-message enable and capable read zero.
// - Bit 23 reads one: 64-bit address capable.
// - Lower address bits 31:2 writable, reset zero; bits 1:0 zero.
// - Downstream port interrupts are routed to the upstream port.
// - Non-zero upper address selects 64-bit write, else 32-bit.
// - Message data fills the low half of the written data.
module ppmsi_regs (
    input  wire logic        sys_clk,        // Core clock, 50 MHz.
    input  wire logic        sys_rst,        // Fundamental reset, synchronous.
    input  wire logic        hot_rst,        // Hot reset, synchronous.
    input  wire logic        is_upstream,    // Port is the upstream port.
    input  wire logic        reg_lock_open,  // Lock open, lockable fields writable.
    input  wire logic        cfg_wr,         // Configuration write strobe.
    input  wire logic        cfg_rd,         // Configuration read strobe.
    input  wire logic [11:0] cfg_addr,       // Byte address of the word.
    input  wire logic [3:0]  cfg_be,         // Byte enables of a write.
    input  wire logic [31:0] cfg_wdata,      // Write data.
    input  wire logic        pme_event,      // Port generates its own PME.
    input  wire logic        pme_fwd,        // PME message merely forwarded.
    input  wire logic        msi_req,        // Interrupt request from the port.
    output logic [31:0]      cfg_rdata,      // Read data.
    output logic             cfg_rd_ack,     // Read data valid pulse.
    output logic [1:0]       power_state,    // Current power state.
    output logic             context_preserved_flag, // No-soft-reset bit.
    output logic             wake_event_enable,      // PME enable bit.
    output logic             wake_event_status,      // PME status bit.
    output logic             pme_msg_req,    // PME message request pulse.
    output logic             msi_enable,     // MSI enable bit.
    output logic             msi_wr_valid,   // MSI write strobe.
    output logic [63:0]      msi_wr_addr,    // MSI write address.
    output logic             msi_wr_wide,    // 64-bit MSI address.
    output logic [31:0]      msi_wr_data,    // MSI write data.
    output logic             msi_route_up    // MSI steered upstream.
);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    ppmsi_pkg::ppmsi_power_state_field_t power_state_field_ff;
    logic        nosoft_ff;
    logic [7:0]  nextcap_ff;
    logic        msien_ff;
    logic [29:0] maddr_ff;
    logic [31:0] muaddr_ff;
    logic [15:0] payload_ff;
    logic [31:0] rdata_ff;
    logic        rdack_ff;

    logic        wr_pm;
    logic        wr_cap;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_dat;
    logic        legal_ps;
    logic        soft_ctx;
    logic        ctx_rst;
    logic [31:0] nxt_rdata;
    logic [31:0] merged_lo;
    logic [31:0] merged_hi;
    logic [31:0] merged_dat;

    assign wr_pm  = cfg_wr && (cfg_addr == `PPMSI_OFF_PMCTL);
    assign wr_cap = cfg_wr && (cfg_addr == `PPMSI_OFF_MSICTL);
    assign wr_lo  = cfg_wr && (cfg_addr == `PPMSI_OFF_MADDR);
    assign wr_hi  = cfg_wr && (cfg_addr == `PPMSI_OFF_MUADDR);
    assign wr_dat = cfg_wr && (cfg_addr == `PPMSI_OFF_MPAY);

    // The two unsupported power states are refused; the state simply stays.
    assign legal_ps = (cfg_wdata[1:0] == ppmsi_pkg::PPMSI_D0)
                   || (cfg_wdata[1:0] == ppmsi_pkg::PPMSI_D3HOT);

    // Leaving the hot low-power state without context preservation wipes the
    // non-sticky context just as a hot reset would.
    assign soft_ctx = wr_pm && cfg_be[0] && !nosoft_ff
                   && (power_state_field_ff == ppmsi_pkg::PPMSI_D3HOT)
                   && (cfg_wdata[1:0] == ppmsi_pkg::PPMSI_D0);
    assign ctx_rst  = sys_rst || hot_rst || soft_ctx;

    assign merged_lo  = ppmsi_pkg::ppmsi_merge({maddr_ff, 2'b00}, cfg_wdata, cfg_be);
    assign merged_hi  = ppmsi_pkg::ppmsi_merge(muaddr_ff, cfg_wdata, cfg_be);
    assign merged_dat = ppmsi_pkg::ppmsi_merge({16'h0, payload_ff}, cfg_wdata, cfg_be);

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            power_state_field_ff <= ppmsi_pkg::PPMSI_D0;
        end else if (wr_pm && cfg_be[0] && legal_ps) begin
            power_state_field_ff <= ppmsi_pkg::ppmsi_power_state_field_t'(cfg_wdata[1:0]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            nosoft_ff <= `PPMSI_RST_NOSOFT;
        end else if (wr_pm && cfg_be[0] && reg_lock_open) begin
            nosoft_ff <= cfg_wdata[`PPMSI_B_NOSOFT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            nextcap_ff <= `PPMSI_RST_NEXTCAP;
        end else if (wr_cap && cfg_be[1] && reg_lock_open) begin
            nextcap_ff <= cfg_wdata[15:8];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            msien_ff <= 1'b0;
        end else if (wr_cap && cfg_be[2]) begin
            msien_ff <= cfg_wdata[`PPMSI_B_MSIEN];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            maddr_ff <= 30'h0;
        end else if (wr_lo) begin
            maddr_ff <= merged_lo[31:2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            muaddr_ff <= `PPMSI_RST_WORD;
        end else if (wr_hi) begin
            muaddr_ff <= merged_hi;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ctx_rst) begin
            payload_ff <= 16'h0;
        end else if (wr_dat) begin
            payload_ff <= merged_dat[15:0];
        end
    end

    // Fields not listed below, and unmapped words, read as zero.
    always_comb begin
        nxt_rdata = `PPMSI_RST_WORD;
        unique case (cfg_addr)
            `PPMSI_OFF_PMCTL: begin
                nxt_rdata[1:0]              = power_state_field_ff;
                nxt_rdata[`PPMSI_B_NOSOFT]  = nosoft_ff;
                nxt_rdata[`PPMSI_B_WAKEEN]  = wake_event_enable;
                nxt_rdata[`PPMSI_B_WAKEST]  = wake_event_status;
                nxt_rdata[14:9]             = 6'h0;
                nxt_rdata[31:24]            = 8'h0;
            end
            `PPMSI_OFF_MSICTL: begin
                nxt_rdata[7:0]              = `PPMSI_CAP_IDENT;
                nxt_rdata[15:8]             = nextcap_ff;
                nxt_rdata[`PPMSI_B_MSIEN]   = msien_ff;
                nxt_rdata[19:17]            = `PPMSI_MMC_VAL;
                nxt_rdata[22:20]            = `PPMSI_MSGEN_VAL;
                nxt_rdata[23]               = `PPMSI_WIDE_VAL;
            end
            `PPMSI_OFF_MADDR:  nxt_rdata = {maddr_ff, 2'b00};
            `PPMSI_OFF_MUADDR: nxt_rdata = muaddr_ff;
            `PPMSI_OFF_MPAY:   nxt_rdata = {16'h0, payload_ff};
            default:           nxt_rdata = `PPMSI_RST_WORD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_ff <= `PPMSI_RST_WORD;
            rdack_ff <= 1'b0;
        end else begin
            rdack_ff <= cfg_rd;
            if (cfg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // A forwarded PME is deliberately not wired to the status logic.
    ppmsi_pme_sticky u_pme (
        .sys_clk           (sys_clk),
        .sys_rst           (sys_rst),
        .hot_rst           (hot_rst),
        .pm_wr             (wr_pm),
        .pm_be             (cfg_be),
        .pm_wdata          (cfg_wdata),
        .pme_event         (pme_event),
        .is_upstream       (is_upstream),
        .wake_event_enable (wake_event_enable),
        .wake_event_status (wake_event_status),
        .pme_msg_req       (pme_msg_req)
    );

    ppmsi_msi_send u_msi (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .hot_rst      (hot_rst),
        .msi_req      (msi_req),
        .msi_en       (msien_ff),
        .addr_lo      ({maddr_ff, 2'b00}),
        .addr_hi      (muaddr_ff),
        .payload      (payload_ff),
        .is_upstream  (is_upstream),
        .msi_wr_valid (msi_wr_valid),
        .msi_wr_addr  (msi_wr_addr),
        .msi_wr_wide  (msi_wr_wide),
        .msi_wr_data  (msi_wr_data),
        .msi_route_up (msi_route_up)
    );

    assign cfg_rdata              = rdata_ff;
    assign cfg_rd_ack             = rdack_ff;
    assign power_state            = power_state_field_ff;
    assign context_preserved_flag = nosoft_ff;
    assign msi_enable             = msien_ff;

    property p_power_state_field_legal;
        power_state_field_ff != 2'b01 && power_state_field_ff != 2'b10;
    endproperty
    a_power_state_field_legal: assert property (p_power_state_field_legal) else $error("illegal power state");

    property p_power_state_field_d3;
        wr_pm && cfg_be[0] && cfg_wdata[1:0] == 2'b11 && !hot_rst |=> power_state == 2'b11;
    endproperty
    a_power_state_field_d3: assert property (p_power_state_field_d3) else $error("D3hot write not taken");

    property p_nosoft_lock;
        !reg_lock_open && !hot_rst && !soft_ctx |=> $stable(nosoft_ff);
    endproperty
    a_nosoft_lock: assert property (p_nosoft_lock) else $error("locked bit changed");

    property p_nextcap_lock;
        !reg_lock_open && !hot_rst && !soft_ctx |=> $stable(nextcap_ff);
    endproperty
    a_nextcap_lock: assert property (p_nextcap_lock) else $error("locked pointer changed");

    property p_fwd_only;
        pme_fwd && !pme_event && !(wr_pm && cfg_be[1]) |=> $stable(wake_event_status);
    endproperty
    a_fwd_only: assert property (p_fwd_only) else $error("forwarded PME set status");

    property p_cap_read;
        cfg_rd && cfg_addr == `PPMSI_OFF_MSICTL |=> cfg_rd_ack && cfg_rdata[7:0] == 8'h05
            && cfg_rdata[23] && cfg_rdata[22:17] == 6'h0 && cfg_rdata[31:24] == 8'h0;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("bad MSI header read");

    property p_pm_read;
        cfg_rd && cfg_addr == `PPMSI_OFF_PMCTL |=> cfg_rdata[14:9] == 6'h0
            && cfg_rdata[31:16] == 16'h0 && cfg_rdata[7:4] == 4'h0 && !cfg_rdata[2];
    endproperty
    a_pm_read: assert property (p_pm_read) else $error("PM data fields not zero");

    property p_addr_low;
        cfg_rd && cfg_addr == `PPMSI_OFF_MADDR |=> cfg_rdata[1:0] == 2'b00;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low bits set");

    property p_power_state_field_refused;
        wr_pm && cfg_be[0] && !legal_ps && !hot_rst |=> $stable(power_state_field_ff);
    endproperty
    a_power_state_field_refused: assert property (p_power_state_field_refused) else $error("bad state");

    property p_hot_clear;
        hot_rst |=> !msi_enable && power_state == 2'b00 && context_preserved_flag;
    endproperty
    a_hot_clear: assert property (p_hot_clear) else $error("hot reset kept context");

    property p_unmapped;
        cfg_rd && !(cfg_addr inside {`PPMSI_OFF_PMCTL, `PPMSI_OFF_MSICTL, `PPMSI_OFF_MADDR,
            `PPMSI_OFF_MUADDR, `PPMSI_OFF_MPAY}) |=> cfg_rdata == `PPMSI_RST_WORD;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped word not zero");

    property p_wake_read;
        cfg_rd && cfg_addr == `PPMSI_OFF_PMCTL
            |=> cfg_rdata[`PPMSI_B_WAKEEN] == $past(wake_event_enable);
    endproperty
    a_wake_read: assert property (p_wake_read) else $error("enable bit misread");

endmodule : ppmsi_regs

// File: common/ppmsi_defines.svh
// Offsets, field positions and reset values of the port PM and MSI registers.
`ifndef PPMSI_DEFINES_SVH
`define PPMSI_DEFINES_SVH

`define PPMSI_OFF_PMCTL    12'h0c4
`define PPMSI_OFF_MSICTL   12'h0d0
`define PPMSI_OFF_MADDR    12'h0d4
`define PPMSI_OFF_MUADDR   12'h0d8
`define PPMSI_OFF_MPAY     12'h0dc

`define PPMSI_B_NOSOFT     3
`define PPMSI_B_WAKEEN     8
`define PPMSI_B_WAKEST     15
`define PPMSI_B_MSIEN      16

`define PPMSI_RST_NOSOFT   1'b1
`define PPMSI_RST_NEXTCAP  8'h00
`define PPMSI_RST_WORD     32'h0000_0000
`define PPMSI_CAP_IDENT    8'h05
`define PPMSI_MMC_VAL      3'h0
`define PPMSI_MSGEN_VAL    3'h0
`define PPMSI_WIDE_VAL     1'b1

`endif

// File: common/ppmsi_pkg.sv
// Types and shared helpers of the port PM and MSI registers.
package ppmsi_pkg;

    typedef enum logic [1:0] {
        PPMSI_D0    = 2'b00,
        PPMSI_D3HOT = 2'b11
    } ppmsi_power_state_field_t;

    // Byte-enable merge of a configuration write into a stored word.
    function automatic logic [31:0] ppmsi_merge(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : ppmsi_merge

endpackage : ppmsi_pkg

// File: core/ppmsi_pme_sticky.sv
// Sticky wake event enable and status bits, kept across hot reset.
`timescale 1ns/1ps
`include "ppmsi_defines.svh"

module ppmsi_pme_sticky (
    input  wire logic sys_clk,           // Core clock.
    input  wire logic sys_rst,           // Fundamental reset, clears sticky bits.
    input  wire logic hot_rst,           // Hot reset, sticky bits ignore it.
    input  wire logic pm_wr,             // Write to the PM control/status word.
    input  wire logic [3:0]  pm_be,      // Byte enables of that write.
    input  wire logic [31:0] pm_wdata,   // Write data.
    input  wire logic pme_event,         // Port itself generates a PME.
    input  wire logic is_upstream,       // Port is the upstream port.
    output logic      wake_event_enable, // Enable bit.
    output logic      wake_event_status, // Status bit.
    output logic      pme_msg_req        // One-cycle PME message request.
);

    logic wen_ff;
    logic wst_ff;
    logic req_ff;
    logic own_pme;

    // The upstream port never originates a PME.
    assign own_pme = pme_event && !is_upstream;

    // Only the fundamental reset clears the enable; hot_rst is not looked at.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wen_ff <= 1'b0;
        end else if (pm_wr && pm_be[1]) begin
            wen_ff <= pm_wdata[`PPMSI_B_WAKEEN];
        end
    end

    // A new PME wins over a simultaneous write-one-to-clear.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wst_ff <= 1'b0;
        end else if (own_pme) begin
            wst_ff <= 1'b1;
        end else if (pm_wr && pm_be[1] && pm_wdata[`PPMSI_B_WAKEST]) begin
            wst_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || hot_rst) begin
            req_ff <= 1'b0;
        end else begin
            req_ff <= own_pme && wen_ff;
        end
    end

    assign wake_event_enable = wen_ff;
    assign wake_event_status = wst_ff;
    assign pme_msg_req       = req_ff;

    property p_wen_hot;
        @(posedge sys_clk) disable iff (sys_rst)
        hot_rst && !pm_wr |=> $stable(wen_ff);
    endproperty
    a_wen_hot: assert property (p_wen_hot) else $error("enable lost on hot reset");

    property p_wst_set;
        @(posedge sys_clk) disable iff (sys_rst)
        own_pme |=> wst_ff;
    endproperty
    a_wst_set: assert property (p_wst_set) else $error("status not set by PME");

    property p_wst_upstream;
        @(posedge sys_clk) disable iff (sys_rst)
        is_upstream && !wst_ff |=> !wst_ff;
    endproperty
    a_wst_upstream: assert property (p_wst_upstream) else $error("upstream status set");

endmodule : ppmsi_pme_sticky

// File: core/ppmsi_msi_send.sv
// Builds the MSI memory write from the capability registers.
`timescale 1ns/1ps
`include "ppmsi_defines.svh"

module ppmsi_msi_send (
    input  wire logic sys_clk,             // Core clock.
    input  wire logic sys_rst,             // Fundamental reset.
    input  wire logic hot_rst,             // Hot reset.
    input  wire logic msi_req,             // One-cycle interrupt request.
    input  wire logic msi_en,              // MSI enable bit.
    input  wire logic [31:0] addr_lo,      // Lower message address.
    input  wire logic [31:0] addr_hi,      // Upper message address.
    input  wire logic [15:0] payload,      // Message data.
    input  wire logic is_upstream,         // Port is the upstream port.
    output logic        msi_wr_valid,      // One-cycle memory write strobe.
    output logic [63:0] msi_wr_addr,       // Write address.
    output logic        msi_wr_wide,       // 64-bit address in use.
    output logic [31:0] msi_wr_data,       // Write data.
    output logic        msi_route_up       // Write steered to the upstream port.
);

    logic        valid_ff;
    logic [63:0] addr_ff;
    logic        wide_ff;
    logic [31:0] data_ff;
    logic        route_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || hot_rst) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= msi_req && msi_en;
        end
    end

    // Payload and address are held after the strobe so a slow consumer can sample them.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || hot_rst) begin
            addr_ff  <= 64'h0;
            wide_ff  <= 1'b0;
            data_ff  <= `PPMSI_RST_WORD;
            route_ff <= 1'b0;
        end else if (msi_req && msi_en) begin
            wide_ff  <= |addr_hi;
            addr_ff  <= (|addr_hi) ? {addr_hi, addr_lo} : {32'h0, addr_lo};
            data_ff  <= {16'h0, payload};
            route_ff <= !is_upstream;
        end
    end

    assign msi_wr_valid = valid_ff;
    assign msi_wr_addr  = addr_ff;
    assign msi_wr_wide  = wide_ff;
    assign msi_wr_data  = data_ff;
    assign msi_route_up = route_ff;

    property p_msi_gated;
        @(posedge sys_clk) disable iff (sys_rst || hot_rst)
        msi_req && !msi_en |=> !msi_wr_valid;
    endproperty
    a_msi_gated: assert property (p_msi_gated) else $error("MSI sent while disabled");

    property p_msi_wide;
        @(posedge sys_clk) disable iff (sys_rst || hot_rst)
        msi_req && msi_en |=> msi_wr_valid && (msi_wr_wide == (msi_wr_addr[63:32] != 32'h0))
            && msi_wr_data[15:0] == $past(payload);
    endproperty
    a_msi_wide: assert property (p_msi_wide) else $error("MSI address form wrong");

endmodule : ppmsi_msi_send

// File: test/ppmsi_host.sv
// Host model that issues configuration reads and writes to the port.
`timescale 1ns/1ps

module ppmsi_host (
    input  wire logic        sys_clk,    // Core clock.
    input  wire logic [31:0] cfg_rdata,  // Read data.
    input  wire logic        cfg_rd_ack, // Read data valid.
    output logic             cfg_wr,     // Write strobe.
    output logic             cfg_rd,     // Read strobe.
    output logic [11:0]      cfg_addr,   // Word address.
    output logic [3:0]       cfg_be,     // Byte enables.
    output logic [31:0]      cfg_wdata   // Write data.
);
    initial begin
        cfg_wr    = 1'b0;
        cfg_rd    = 1'b0;
        cfg_addr  = 12'h000;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge sys_clk);
        cfg_wr    <= 1'b1;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr    <= 1'b0;
        // A released data bus must not keep showing the last value.
        cfg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        cfg_rd   <= 1'b1;
        cfg_addr <= a;
        @(posedge sys_clk);
        cfg_rd   <= 1'b0;
        #1;
        d = (cfg_rd_ack === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
    endtask : rd

    // Boot agent loads the wake enable so a hot-plug wakeup stays possible.
    task automatic boot_load();
        wr(12'h0c4, 4'h2, 32'h0000_0100);
    endtask : boot_load

    // Only addresses that route towards the root are ever programmed.
    task automatic prog_msi(input logic [31:0] lo, input logic [31:0] hi);
        wr(12'h0d4, 4'hf, lo);
        wr(12'h0d8, 4'hf, hi);
    endtask : prog_msi
endmodule : ppmsi_host

// File: test/testbench.sv
// Self-checking testbench of the port PM and MSI registers.
`timescale 1ns/1ps

module testbench;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hot_rst = 1'b0;
    logic        is_upstream = 1'b0;
    logic        reg_lock_open = 1'b0;
    logic        pme_event = 1'b0;
    logic        pme_fwd = 1'b0;
    logic        msi_req = 1'b0;
    logic        cfg_wr, cfg_rd, cfg_rd_ack, ctx_flag, wake_en, wake_st, pme_req;
    logic        msi_en, msi_wr_valid, msi_wr_wide, msi_route_up;
    logic [1:0]  power_state;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, msi_wr_data, rd_val;
    logic [63:0] msi_wr_addr;
    int          err_total = 0;
    int          n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    ppmsi_regs ppmsi_regs_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hot_rst(hot_rst),
        .is_upstream(is_upstream), .reg_lock_open(reg_lock_open),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .pme_event(pme_event), .pme_fwd(pme_fwd),
        .msi_req(msi_req), .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
        .power_state(power_state), .context_preserved_flag(ctx_flag),
        .wake_event_enable(wake_en), .wake_event_status(wake_st),
        .pme_msg_req(pme_req), .msi_enable(msi_en), .msi_wr_valid(msi_wr_valid),
        .msi_wr_addr(msi_wr_addr), .msi_wr_wide(msi_wr_wide),
        .msi_wr_data(msi_wr_data), .msi_route_up(msi_route_up));

    ppmsi_host ppmsi_host_inst (
        .sys_clk(sys_clk), .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata));

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        ppmsi_host_inst.rd(a, rd_val);
        chk("cfg_rdata", {32'h0, e}, {32'h0, rd_val});
    endtask : rchk

    // Kind 0 own PME, 1 forwarded PME, 2 interrupt request, 3 hot reset.
    task automatic pulse(input int k);
        @(posedge sys_clk);
        pme_event <= (k == 0);
        pme_fwd   <= (k == 1);
        msi_req   <= (k == 2);
        hot_rst   <= (k == 3);
        @(posedge sys_clk);
        pme_event <= 1'b0;
        pme_fwd   <= 1'b0;
        msi_req   <= 1'b0;
        hot_rst   <= 1'b0;
        #1;
    endtask : pulse

    task automatic t_reset();
        rchk(12'h0c4, 32'h0000_0008);
        rchk(12'h0d0, 32'h0080_0005);
        rchk(12'h0d4, 32'h0000_0000);
        rchk(12'h0e0, 32'h0000_0000);
        chk("context_preserved_flag", 64'h1, {63'h0, ctx_flag});
        chk("msi_enable", 64'h0, {63'h0, msi_en});
    endtask : t_reset

    task automatic t_power_state_field();
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0003);
        rchk(12'h0c4, 32'h0000_000b);
        chk("power_state", 64'h3, {62'h0, power_state});
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0001);
        rchk(12'h0c4, 32'h0000_000b);
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0002);
        rchk(12'h0c4, 32'h0000_000b);
        ppmsi_host_inst.wr(12'h0c4, 4'hf, 32'hffff_ffff);
        rchk(12'h0c4, 32'h0000_010b);
        ppmsi_host_inst.wr(12'h0c4, 4'hf, 32'h0000_0000);
        rchk(12'h0c4, 32'h0000_0008);
    endtask : t_power_state_field

    task automatic t_lock();
        ppmsi_host_inst.wr(12'h0d0, 4'h2, 32'h0000_ab00);
        rchk(12'h0d0, 32'h0080_0005);
        @(posedge sys_clk) reg_lock_open <= 1'b1;
        ppmsi_host_inst.wr(12'h0d0, 4'h2, 32'h0000_ab00);
        rchk(12'h0d0, 32'h0080_ab05);
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0000);
        rchk(12'h0c4, 32'h0000_0000);
        chk("context_preserved_flag", 64'h0, {63'h0, ctx_flag});
        @(posedge sys_clk) reg_lock_open <= 1'b0;
        ppmsi_host_inst.wr(12'h0d4, 4'hf, 32'h1234_5678);
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0003);
        ppmsi_host_inst.wr(12'h0c4, 4'h1, 32'h0000_0000);
        rchk(12'h0d4, 32'h0000_0000);
        rchk(12'h0c4, 32'h0000_0008);
        rchk(12'h0d0, 32'h0080_0005);
    endtask : t_lock

    task automatic t_msi();
        ppmsi_host_inst.prog_msi(32'hffff_ffff, 32'h0000_0000);
        rchk(12'h0d4, 32'hffff_fffc);
        pulse(2);
        chk("msi_wr_valid", 64'h0, {63'h0, msi_wr_valid});
        ppmsi_host_inst.wr(12'h0d0, 4'h4, 32'h0071_0000);
        rchk(12'h0d0, 32'h0081_0005);
        ppmsi_host_inst.wr(12'h0dc, 4'hf, 32'hffff_1234);
        rchk(12'h0dc, 32'h0000_1234);
        pulse(2);
        chk("msi_wr_valid", 64'h1, {63'h0, msi_wr_valid});
        chk("msi_wr_addr", 64'h0000_0000_ffff_fffc, msi_wr_addr);
        chk("msi_wr_wide", 64'h0, {63'h0, msi_wr_wide});
        chk("msi_wr_data", 64'h0000_1234, {32'h0, msi_wr_data});
        chk("msi_route_up", 64'h1, {63'h0, msi_route_up});
        ppmsi_host_inst.prog_msi(32'hffff_fffc, 32'h0000_0001);
        pulse(2);
        chk("msi_wr_addr", 64'h0000_0001_ffff_fffc, msi_wr_addr);
        chk("msi_wr_wide", 64'h1, {63'h0, msi_wr_wide});
        @(posedge sys_clk);
        #1;
        chk("msi_wr_valid", 64'h0, {63'h0, msi_wr_valid});
    endtask : t_msi

    task automatic t_pme();
        pulse(0);
        chk("wake_event_status", 64'h1, {63'h0, wake_st});
        chk("pme_msg_req", 64'h0, {63'h0, pme_req});
        ppmsi_host_inst.wr(12'h0c4, 4'h2, 32'h0000_8000);
        rchk(12'h0c4, 32'h0000_0008);
        pulse(1);
        chk("wake_event_status", 64'h0, {63'h0, wake_st});
        ppmsi_host_inst.boot_load();
        pulse(0);
        chk("pme_msg_req", 64'h1, {63'h0, pme_req});
        pulse(3);
        chk("wake_event_enable", 64'h1, {63'h0, wake_en});
        chk("wake_event_status", 64'h1, {63'h0, wake_st});
    endtask : t_pme

    task automatic t_up();
        @(posedge sys_clk);
        sys_rst     <= 1'b1;
        is_upstream <= 1'b1;
        @(posedge sys_clk) sys_rst <= 1'b0;
        #1;
        chk("wake_event_enable", 64'h0, {63'h0, wake_en});
        ppmsi_host_inst.boot_load();
        pulse(0);
        chk("wake_event_status", 64'h0, {63'h0, wake_st});
        ppmsi_host_inst.wr(12'h0d0, 4'h4, 32'h0001_0000);
        pulse(2);
        chk("msi_enable", 64'h1, {63'h0, msi_en});
        chk("msi_route_up", 64'h0, {63'h0, msi_route_up});
    endtask : t_up

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_power_state_field();
        t_lock();
        t_msi();
        t_pme();
        t_up();
        results();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule : testbench
